/* File: core/ifd_decoder.sv */
// Top of the instruction field decoder: one registered stage of decoded fields.
// Assumes the prefetch stage presents opcode, second byte, sib and immediate
// bytes of one instruction together with in_valid, synchronous to clock.
`default_nettype none
module ifd_decoder
  import ifd_pkg::*;
(
  // Clock, reset and enable
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // Instruction bytes from prefetch
  input wire logic in_valid,
  input wire logic [7:0] op_byte0,
  input wire logic [7:0] op_byte1,
  input wire logic [7:0] sib_byte,
  input wire logic [7:0] imm8,
  // Decode context from prefetch
  input wire logic addr32,
  input wire logic has_dir,
  input wire logic has_sign,
  input wire logic imm_is_8,
  input wire logic [1:0] dest_width,
  input wire logic is_cond,
  input wire logic [1:0] sreg_class,
  // Arithmetic flags for the condition test
  input wire logic flag_carry,
  input wire logic flag_parity,
  input wire logic flag_zero,
  input wire logic flag_sign,
  input wire logic flag_overflow,
  // Address generation fields
  output logic out_valid,
  output logic sib_present,
  output logic [2:0] disp_bytes,
  output logic [3:0] scale_factor,
  output logic [2:0] index_reg,
  output logic index_used,
  output logic [2:0] base_code,
  output logic ea_undefined,
  // Operand and immediate control
  output logic reg_is_dest,
  output logic [31:0] imm_value,
  output logic imm_sign_extended,
  // Condition test
  output logic [2:0] cond_code,
  output logic cond_negate,
  output logic cond_true,
  // Special register selection
  output logic [2:0] sreg_index,
  output logic sreg_valid,
  output logic invalid_opcode,
  // Floating point fields
  output logic is_fp,
  output logic [2:0] fp_form,
  output logic [1:0] memory_format,
  output logic fp_pop,
  output logic fp_dest_is_elem,
  output logic fp_src_op_dest,
  output logic [2:0] stack_element
);

  // Addressing decode shared by integer and floating instructions
  ifd_ea_if ea ();

  ifd_ea_decode u_ea (
    .ea(ea)
  );

  // Same bytes feed the decoder whatever the instruction class
  assign ea.modrm = op_byte1;
  assign ea.sib = sib_byte;
  assign ea.addr32 = addr32;

  // Second byte fields
  wire [1:0] mode = op_byte1[7:6];  // Mode field
  wire [2:0] sel = op_byte1[5:3];   // Special register selector
  wire [2:0] elem = op_byte1[2:0];  // Stack element field

  // Direction: 1 makes reg field the destination
  wire dir_dest = has_dir & op_byte0[IFD_DIR_BIT];

  // Sign extension only for byte immediate into 16 or 32 bits
  wire wide_dest = (dest_width == IFD_W16) | (dest_width == IFD_W32);
  wire sext_on = has_sign & op_byte0[IFD_DIR_BIT] & imm_is_8 & wide_dest;
  wire [7:0] fill8 = {8{imm8[7]}};
  logic [31:0] imm_nxt;

  // Immediate value: without extension the byte is passed zero-filled
  always_comb begin
    imm_nxt = {24'h00_0000, imm8};
    if (sext_on) begin
      if (dest_width == IFD_W16) begin
        imm_nxt = {16'h0000, fill8, imm8};
      end else begin
        imm_nxt = {fill8, fill8, fill8, imm8};
      end
    end
  end

  // Condition field is the low nibble of the opcode byte
  wire [2:0] ttt = op_byte0[3:1];
  wire cond_n = op_byte0[0];
  wire less = flag_sign ^ flag_overflow;
  logic base_true;

  // Condition before negation
  always_comb begin
    base_true = 1'b0;
    unique case (ifd_cond_e'(ttt))
      IFD_C_OVERFLOW: base_true = flag_overflow;
      IFD_C_BELOW:    base_true = flag_carry;
      IFD_C_EQUAL:    base_true = flag_zero;
      IFD_C_BELOW_EQ: base_true = flag_carry | flag_zero;
      IFD_C_SIGN:     base_true = flag_sign;
      IFD_C_PARITY:   base_true = flag_parity;
      IFD_C_LESS:     base_true = less;
      IFD_C_LESS_EQ:  base_true = less | flag_zero;
    endcase
  end

  // Odd code tests the negation
  wire cond_eval = is_cond & (base_true ^ cond_n);

  // Special register code check, one mask bit per code
  logic [7:0] sreg_mask;

  // Mask of codes defined for the addressed class
  always_comb begin
    sreg_mask = 8'h00;
    unique case (ifd_sreg_e'(sreg_class))
      IFD_SR_NONE:    sreg_mask = 8'h00;
      IFD_SR_CONTROL: sreg_mask = IFD_CTRL_MASK;
      IFD_SR_DEBUG:   sreg_mask = IFD_DBG_MASK;
      IFD_SR_TEST:    sreg_mask = IFD_TEST_MASK;
    endcase
  end

  wire sreg_class_on = (sreg_class != IFD_SR_NONE);
  wire sreg_ok = sreg_class_on & sreg_mask[sel];
  // Undefined code traps rather than silently touching a register
  wire sreg_bad = sreg_class_on & ~sreg_mask[sel];

  // Floating point classification by lead pattern
  wire fp_hit = (op_byte0[7:3] == IFD_FP_LEAD);
  wire fp_regform = (mode == IFD_MOD_REG);
  wire f45_top = (op_byte1[7:5] == IFD_FP_F45_TOP);
  wire f4 = fp_regform & f45_top & (op_byte0[2:0] == IFD_FP_F4_LOW);
  wire f5 = fp_regform & f45_top & (op_byte0[2:0] == IFD_FP_F5_LOW);
  wire f3 = fp_regform & ~f4 & ~f5;
  logic [2:0] form_nxt;

  // Form selection; memory forms share one code
  always_comb begin
    form_nxt = IFD_FF_NONE;
    if (!fp_hit) begin
      form_nxt = IFD_FF_NONE;
    end else if (!fp_regform) begin
      form_nxt = IFD_FF_MEM;
    end else if (f4) begin
      form_nxt = IFD_FF_F4;
    end else if (f5) begin
      form_nxt = IFD_FF_F5;
    end else begin
      form_nxt = IFD_FF_REG;
    end
  end

  // Register form fields only count in the register form
  wire fp_reg3 = fp_hit & f3;
  wire pop_nxt = fp_reg3 & op_byte0[IFD_FP_POP_BIT];
  wire dst_nxt = fp_reg3 & op_byte0[IFD_FP_DEST_BIT];
  // Operand order from reverse xor destination
  wire ord_nxt = fp_reg3 & (op_byte1[IFD_FP_REV_BIT] ^ op_byte0[IFD_FP_DEST_BIT]);
  // Memory format sits where the register form keeps d and P
  wire [1:0] mf_nxt = (fp_hit & ~fp_regform) ? op_byte0[2:1] : IFD_MF_REAL32;
  wire [2:0] elem_nxt = fp_reg3 ? elem : 3'h0;

  // Output stage registers
  logic valid_r;
  logic sib_r;
  logic [2:0] disp_r;
  logic [3:0] scale_r;
  logic [2:0] index_r;
  logic index_used_r;
  logic [2:0] base_r;
  logic undef_r;
  logic dir_r;
  logic [31:0] imm_r;
  logic sext_r;
  logic [2:0] cond_r;
  logic neg_r;
  logic ctrue_r;
  logic [2:0] sidx_r;
  logic sok_r;
  logic bad_r;
  logic fp_r;
  logic [2:0] form_r;
  logic [1:0] mf_r;
  logic pop_r;
  logic dst_r;
  logic ord_r;
  logic [2:0] elem_r;

  // Validity and trap; trap only on a valid instruction
  always_ff @(posedge clock) begin
    if (reset) begin
      valid_r <= 1'b0;
      bad_r <= 1'b0;
    end else if (clock_enable) begin
      valid_r <= in_valid;
      bad_r <= in_valid & sreg_bad;
    end
  end

  // Address generation fields, taken with each valid instruction
  always_ff @(posedge clock) begin
    if (reset) begin
      sib_r <= 1'b0;
      disp_r <= IFD_DISP_0;
      scale_r <= IFD_SCALE_RST;
      index_r <= IFD_NO_INDEX;
      index_used_r <= 1'b0;
      base_r <= 3'h0;
      undef_r <= 1'b0;
    end else if (clock_enable && in_valid) begin
      sib_r <= ea.sib_present;
      disp_r <= ea.disp_bytes;
      scale_r <= ea.scale;
      index_r <= ea.index_reg;
      index_used_r <= ea.index_used;
      base_r <= ea.base_code;
      undef_r <= ea.ea_undefined;
    end
  end

  // Integer operand, immediate and condition fields
  always_ff @(posedge clock) begin
    if (reset) begin
      dir_r <= 1'b0;
      imm_r <= IFD_IMM_RST;
      sext_r <= 1'b0;
      cond_r <= IFD_C_OVERFLOW;
      neg_r <= 1'b0;
      ctrue_r <= 1'b0;
    end else if (clock_enable && in_valid) begin
      dir_r <= dir_dest;
      imm_r <= imm_nxt;
      sext_r <= sext_on;
      cond_r <= ttt;
      neg_r <= cond_n;
      ctrue_r <= cond_eval;
    end
  end

  // Special register and floating point fields
  always_ff @(posedge clock) begin
    if (reset) begin
      sidx_r <= 3'h0;
      sok_r <= 1'b0;
      fp_r <= 1'b0;
      form_r <= IFD_FF_NONE;
      mf_r <= IFD_MF_REAL32;
      pop_r <= 1'b0;
      dst_r <= 1'b0;
      ord_r <= 1'b0;
      elem_r <= 3'h0;
    end else if (clock_enable && in_valid) begin
      sidx_r <= sel;
      sok_r <= sreg_ok;
      fp_r <= fp_hit;
      form_r <= form_nxt;
      mf_r <= mf_nxt;
      pop_r <= pop_nxt;
      dst_r <= dst_nxt;
      ord_r <= ord_nxt;
      elem_r <= elem_nxt;
    end
  end

  // Outputs straight from the stage
  assign out_valid = valid_r;
  assign sib_present = sib_r;
  assign disp_bytes = disp_r;
  assign scale_factor = scale_r;
  assign index_reg = index_r;
  assign index_used = index_used_r;
  assign base_code = base_r;
  assign ea_undefined = undef_r;
  assign reg_is_dest = dir_r;
  assign imm_value = imm_r;
  assign imm_sign_extended = sext_r;
  assign cond_code = cond_r;
  assign cond_negate = neg_r;
  assign cond_true = ctrue_r;
  assign sreg_index = sidx_r;
  assign sreg_valid = sok_r;
  assign invalid_opcode = bad_r;
  assign is_fp = fp_r;
  assign fp_form = form_r;
  assign memory_format = mf_r;
  assign fp_pop = pop_r;
  assign fp_dest_is_elem = dst_r;
  assign fp_src_op_dest = ord_r;
  assign stack_element = elem_r;

endmodule
`default_nettype wire

/* File: core/ifd_ea_decode.sv */
// Combinational decode of the mode/register-memory and scale-index-base bytes.
// Assumes the bytes on the interface belong to one instruction.
`default_nettype none
module ifd_ea_decode
  import ifd_pkg::*;
(
  // Addressing bytes in, fields out
  ifd_ea_if.decoder ea
);
  wire [1:0] mode = ea.modrm[7:6];  // Mode field
  wire [2:0] rm = ea.modrm[2:0];    // Register/memory field
  wire [1:0] ss = ea.sib[7:6];      // Scale selector
  wire [2:0] idx = ea.sib[5:3];     // Index code
  wire [2:0] base = ea.sib[2:0];    // Base code
  wire is_mem = (mode != IFD_MOD_REG);
  // Only 32-bit addressing knows the extra byte
  wire sib_here = ea.addr32 & is_mem & (rm == IFD_RM_SIB);
  // Bare displacement cases with mode 00
  wire bare32 = ea.addr32 & (mode == IFD_MOD_NODISP) &
                (sib_here ? (base == IFD_BASE_D32) : (rm == IFD_RM_D32));
  wire bare16 = ~ea.addr32 & (mode == IFD_MOD_NODISP) & (rm == IFD_RM_D16);
  wire [2:0] wide_disp = ea.addr32 ? IFD_DISP_4 : IFD_DISP_2;
  logic [2:0] disp;

  // Displacement length follows mode and register/memory, as for integers
  always_comb begin
    disp = IFD_DISP_0;
    if (!is_mem) begin
      disp = IFD_DISP_0;  // Register operand, nothing follows
    end else if (mode == IFD_MOD_DISP8) begin
      disp = IFD_DISP_1;
    end else if (mode == IFD_MOD_NODISP) begin
      disp = (bare32 | bare16) ? wide_disp : IFD_DISP_0;
    end else begin
      disp = wide_disp;
    end
  end

  assign ea.sib_present = sib_here;
  assign ea.disp_bytes = disp;
  // Scale is a shift of one by the selector
  assign ea.scale = 4'h1 << ss;
  assign ea.index_reg = ifd_gpr_e'(idx);
  // Code 100 adds nothing to the address
  assign ea.index_used = sib_here & (idx != IFD_IDX_NONE);
  assign ea.base_code = base;
  // Flagged only; the address computed by others is then not trusted
  assign ea.ea_undefined = sib_here & (idx == IFD_IDX_NONE) & (ss != 2'h0);
endmodule
`default_nettype wire

/* File: core/ifd_ea_if.sv */
// Interface carrying addressing bytes to the effective-address decoder
// and its decoded fields back. Assumes one clock domain, no timing.
`default_nettype none
interface ifd_ea_if;
  import ifd_pkg::*;
  logic [7:0] modrm;      // Mode / reg / register-memory byte
  logic [7:0] sib;        // Scale-index-base byte
  logic addr32;           // High for 32-bit address mode
  logic sib_present;      // A scale-index-base byte follows
  logic [2:0] disp_bytes; // Displacement length
  logic [3:0] scale;      // Index multiplier 1, 2, 4 or 8
  ifd_gpr_e index_reg;    // Index register code
  logic index_used;       // Index contributes to the address
  logic [2:0] base_code;  // Base register code
  logic ea_undefined;     // No index but scale not one
  modport decoder (input modrm, sib, addr32,
    output sib_present, disp_bytes, scale, index_reg, index_used, base_code, ea_undefined);
  modport user (output modrm, sib, addr32,
    input sib_present, disp_bytes, scale, index_reg, index_used, base_code, ea_undefined);
endinterface
`default_nettype wire

/* File: core/ifd_pkg.sv */
// Package for the instruction field decoder: field positions, codes, masks.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ifd_pkg;
  // Mode field value that names a register operand
  localparam logic [1:0] IFD_MOD_REG = 2'h3;
  localparam logic [1:0] IFD_MOD_NODISP = 2'h0;
  localparam logic [1:0] IFD_MOD_DISP8 = 2'h1;
  // Register/memory code that announces a scale-index-base byte
  localparam logic [2:0] IFD_RM_SIB = 3'h4;
  // Register/memory codes meaning a bare displacement
  localparam logic [2:0] IFD_RM_D32 = 3'h5;
  localparam logic [2:0] IFD_RM_D16 = 3'h6;
  // Index code meaning no index register
  localparam logic [2:0] IFD_IDX_NONE = 3'h4;
  // Base code meaning a bare 32-bit displacement when mode is 00
  localparam logic [2:0] IFD_BASE_D32 = 3'h5;
  // Displacement lengths in bytes
  localparam logic [2:0] IFD_DISP_0 = 3'h0;
  localparam logic [2:0] IFD_DISP_1 = 3'h1;
  localparam logic [2:0] IFD_DISP_2 = 3'h2;
  localparam logic [2:0] IFD_DISP_4 = 3'h4;
  // Five-bit lead pattern of floating point instructions
  localparam logic [4:0] IFD_FP_LEAD = 5'h1B;
  // Bit positions inside the two floating point bytes
  localparam int IFD_FP_DEST_BIT = 2;
  localparam int IFD_FP_POP_BIT = 1;
  localparam int IFD_FP_REV_BIT = 3;
  // Direction and sign-extend bit position in the opcode byte
  localparam int IFD_DIR_BIT = 1;
  // Low opcode bits and second byte top bits of forms 4 and 5
  localparam logic [2:0] IFD_FP_F4_LOW = 3'h1;
  localparam logic [2:0] IFD_FP_F5_LOW = 3'h3;
  localparam logic [2:0] IFD_FP_F45_TOP = 3'h7;
  // Valid special-register codes, one bit per code
  localparam logic [7:0] IFD_CTRL_MASK = 8'h0D;
  localparam logic [7:0] IFD_DBG_MASK = 8'hCF;
  localparam logic [7:0] IFD_TEST_MASK = 8'hF8;
  // Reset values of the output stage
  localparam logic [31:0] IFD_IMM_RST = 32'h0000_0000;
  localparam logic [3:0] IFD_SCALE_RST = 4'h1;

  // General register codes used for index and base
  typedef enum logic [2:0] {
    IFD_ACCUMULATOR_REG = 3'b000, IFD_COUNT_REG = 3'b001,
    IFD_DATA_REG = 3'b010, IFD_BASE_REG = 3'b011,
    IFD_NO_INDEX = 3'b100, IFD_FRAME_POINTER_REG = 3'b101,
    IFD_SOURCE_INDEX_REG = 3'b110, IFD_DEST_INDEX_REG = 3'b111
  } ifd_gpr_e;
  // Tested conditions, upper three bits of the condition field
  typedef enum logic [2:0] {
    IFD_C_OVERFLOW = 3'b000, IFD_C_BELOW = 3'b001,
    IFD_C_EQUAL = 3'b010, IFD_C_BELOW_EQ = 3'b011,
    IFD_C_SIGN = 3'b100, IFD_C_PARITY = 3'b101,
    IFD_C_LESS = 3'b110, IFD_C_LESS_EQ = 3'b111
  } ifd_cond_e;
  // Class of special register addressed by the selector
  typedef enum logic [1:0] {
    IFD_SR_NONE = 2'b00, IFD_SR_CONTROL = 2'b01,
    IFD_SR_DEBUG = 2'b10, IFD_SR_TEST = 2'b11
  } ifd_sreg_e;
  // Destination width of an immediate operation
  typedef enum logic [1:0] {
    IFD_W8 = 2'b00, IFD_W16 = 2'b01, IFD_W32 = 2'b10
  } ifd_width_e;
  // Floating point memory format
  typedef enum logic [1:0] {
    IFD_MF_REAL32 = 2'b00, IFD_MF_INT32 = 2'b01,
    IFD_MF_REAL64 = 2'b10, IFD_MF_INT16 = 2'b11
  } ifd_mf_e;
  // Floating point instruction form
  typedef enum logic [2:0] {
    IFD_FF_NONE = 3'b000, IFD_FF_MEM = 3'b010,
    IFD_FF_REG = 3'b011, IFD_FF_F4 = 3'b100, IFD_FF_F5 = 3'b101
  } ifd_fpform_e;
endpackage
`default_nettype wire

/* File: testbench/ifd_decoder_sva.sv */
// Checker for the instruction field decoder top, watching its ports only.
// Assumes a bind onto ifd_decoder with every pin connected by name.
`default_nettype none
module ifd_decoder_sva
  import ifd_pkg::*;
(
  // Clock, reset and request side
  input wire logic clock, reset, clock_enable, in_valid, has_dir, has_sign, imm_is_8,
  input wire logic [7:0] op_byte0, op_byte1, sib_byte, imm8,
  input wire logic [1:0] sreg_class,
  // Decoded fields
  input wire logic sib_present, index_used, ea_undefined, reg_is_dest, cond_negate, invalid_opcode, is_fp,
  input wire logic fp_pop, fp_dest_is_elem, fp_src_op_dest,
  input wire logic [3:0] scale_factor,
  input wire logic [2:0] index_reg, base_code, cond_code, fp_form, stack_element,
  input wire logic [1:0] memory_format,
  input wire logic [31:0] imm_value
);
  timeunit 1ns / 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Taken only outside reset, so $past never sees a reset-cycle request
  wire logic take = clock_enable && in_valid && !reset;
  // Valid-code mask of the addressed class
  wire logic [7:0] mask_sel = (sreg_class == IFD_SR_CONTROL) ? IFD_CTRL_MASK :
    (sreg_class == IFD_SR_DEBUG) ? IFD_DBG_MASK : IFD_TEST_MASK;

  sib_split_a: assert property ($past(take) && sib_present |->
    scale_factor == (4'h1 << $past(sib_byte[7:6])) && index_reg == $past(sib_byte[5:3])
    && base_code == $past(sib_byte[2:0])) else $error("sib fields wrong");
  index_none_a: assert property ($past(take) && sib_present |->
    index_used == ($past(sib_byte[5:3]) != IFD_IDX_NONE)) else $error("index use wrong");
  ea_undef_a: assert property ($past(take) && sib_present |->
    ea_undefined == ($past(sib_byte[5:3]) == IFD_IDX_NONE && $past(sib_byte[7:6]) != 2'h0))
    else $error("undefined address flag wrong");
  dir_swap_a: assert property ($past(take) |->
    reg_is_dest == $past(has_dir && op_byte0[IFD_DIR_BIT])) else $error("direction wrong");
  zero_fill_a: assert property ($past(take && imm_is_8 && !(has_sign && op_byte0[1])) |->
    imm_value == {24'h000000, $past(imm8)}) else $error("immediate not zero filled");
  cond_split_a: assert property ($past(take) |->
    cond_code == $past(op_byte0[3:1]) && cond_negate == $past(op_byte0[0])) else $error("condition split wrong");
  fp_lead_a: assert property ($past(take) |->
    is_fp == ($past(op_byte0[7:3]) == IFD_FP_LEAD)) else $error("fp class wrong");
  fp_format_a: assert property ($past(take) && fp_form == IFD_FF_MEM |->
    memory_format == $past(op_byte0[2:1])) else $error("memory format wrong");
  fp_pop_dest_a: assert property ($past(take) && fp_form == IFD_FF_REG |->
    fp_pop == $past(op_byte0[IFD_FP_POP_BIT]) && fp_dest_is_elem == $past(op_byte0[IFD_FP_DEST_BIT]))
    else $error("pop or destination wrong");
  fp_order_a: assert property ($past(take) && fp_form == IFD_FF_REG |->
    fp_src_op_dest == $past(op_byte1[IFD_FP_REV_BIT] ^ op_byte0[IFD_FP_DEST_BIT])
    && stack_element == $past(op_byte1[2:0])) else $error("operand order wrong");
  sreg_check_a: assert property ($past(take && sreg_class != IFD_SR_NONE) |->
    invalid_opcode == !$past(mask_sel[op_byte1[5:3]])) else $error("invalid code flag wrong");

  // Main scenarios reached
  cover property ($past(take) && ea_undefined);
  cover property (fp_form == IFD_FF_REG && fp_pop);
  cover property (invalid_opcode);
endmodule
`default_nettype wire

/* File: testbench/ifd_prefetch_model.sv */
// Prefetch-stage model: presents one instruction and its context per cycle.
// Assumes the bench calls its tasks; inputs change on the falling edge.
`default_nettype none
module ifd_prefetch_model (
  // Clock
  input wire logic clock,
  // Toward the decoder
  output logic clock_enable, in_valid, addr32, has_dir, has_sign, imm_is_8, is_cond,
  output logic [7:0] op_byte0, op_byte1, sib_byte, imm8,
  output logic [1:0] dest_width, sreg_class,
  output logic flag_carry, flag_parity, flag_zero, flag_sign, flag_overflow
);
  timeunit 1ns / 100ps;
  // Quiet until the bench issues anything
  initial begin
    {clock_enable, in_valid, addr32, has_dir, has_sign, imm_is_8, is_cond, op_byte0, op_byte1, sib_byte} = 31'h0;
    {imm8, dest_width, sreg_class, flag_carry, flag_parity, flag_zero, flag_sign, flag_overflow} = 17'h0;
  end
  // One instruction; ctx = addr32,dir,sign,imm8,width,cond,class; fl = c,p,z,s,o
  // Scale stays 00 with index code 000 unless a scenario breaks it on purpose
  task issue(input logic en, input logic [7:0] b0, b1, sb, im, input logic [8:0] ctx, input logic [4:0] fl);
    @(negedge clock);
    clock_enable = en;
    in_valid = 1'b1;
    {op_byte0, op_byte1, sib_byte, imm8} = {b0, b1, sb, im};
    {addr32, has_dir, has_sign, imm_is_8, dest_width, is_cond, sreg_class} = ctx;
    {flag_carry, flag_parity, flag_zero, flag_sign, flag_overflow} = fl;
    @(posedge clock);
    #1;
  endtask
  // A cycle with no instruction
  task idle(input logic en);
    @(negedge clock);
    clock_enable = en;
    in_valid = 1'b0;
    @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_instr_field_decoder.sv */
// Bench for the instruction field decoder with a prefetch model as driver.
// Assumes the package, interface and decoder files compile first.
`default_nettype none
module tb_instr_field_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  import ifd_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  wire logic clock_enable, in_valid, addr32, has_dir, has_sign, imm_is_8, is_cond;
  wire logic flag_carry, flag_parity, flag_zero, flag_sign, flag_overflow;
  wire logic [7:0] op_byte0, op_byte1, sib_byte, imm8;
  wire logic [1:0] dest_width, sreg_class, memory_format;
  wire logic out_valid, sib_present, index_used, ea_undefined, reg_is_dest, imm_sign_extended;
  wire logic cond_negate, cond_true, sreg_valid, invalid_opcode, is_fp, fp_pop, fp_dest_is_elem, fp_src_op_dest;
  wire logic [2:0] disp_bytes, index_reg, base_code, cond_code, sreg_index, fp_form, stack_element;
  wire logic [3:0] scale_factor;
  wire logic [31:0] imm_value;

  always #10 clock = ~clock;

  ifd_prefetch_model u_pf (.clock(clock), .clock_enable(clock_enable), .in_valid(in_valid), .addr32(addr32),
    .has_dir(has_dir), .has_sign(has_sign), .imm_is_8(imm_is_8), .is_cond(is_cond), .op_byte0(op_byte0),
    .op_byte1(op_byte1), .sib_byte(sib_byte), .imm8(imm8), .dest_width(dest_width), .sreg_class(sreg_class),
    .flag_carry(flag_carry), .flag_parity(flag_parity), .flag_zero(flag_zero), .flag_sign(flag_sign),
    .flag_overflow(flag_overflow));
  ifd_decoder u_dut (.clock(clock), .reset(reset), .clock_enable(clock_enable), .in_valid(in_valid),
    .op_byte0(op_byte0), .op_byte1(op_byte1), .sib_byte(sib_byte), .imm8(imm8), .addr32(addr32),
    .has_dir(has_dir), .has_sign(has_sign), .imm_is_8(imm_is_8), .dest_width(dest_width), .is_cond(is_cond),
    .sreg_class(sreg_class), .flag_carry(flag_carry), .flag_parity(flag_parity), .flag_zero(flag_zero),
    .flag_sign(flag_sign), .flag_overflow(flag_overflow), .out_valid(out_valid), .sib_present(sib_present),
    .disp_bytes(disp_bytes), .scale_factor(scale_factor), .index_reg(index_reg), .index_used(index_used),
    .base_code(base_code), .ea_undefined(ea_undefined), .reg_is_dest(reg_is_dest), .imm_value(imm_value),
    .imm_sign_extended(imm_sign_extended), .cond_code(cond_code), .cond_negate(cond_negate),
    .cond_true(cond_true), .sreg_index(sreg_index), .sreg_valid(sreg_valid), .invalid_opcode(invalid_opcode),
    .is_fp(is_fp), .fp_form(fp_form), .memory_format(memory_format), .fp_pop(fp_pop),
    .fp_dest_is_elem(fp_dest_is_elem), .fp_src_op_dest(fp_src_op_dest), .stack_element(stack_element));

  // Compare and count; four-state so an unknown never matches
  task check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  // Condition value from flags f = c,p,z,s,o, worked out independently
  function automatic logic cond_of(input logic [2:0] t, input logic [4:0] f);
    logic [7:0] v;
    v = {(f[1] ^ f[0]) | f[2], f[1] ^ f[0], f[3], f[1], f[4] | f[2], f[2], f[4], f[0]};
    return v[t];
  endfunction

  // Every scale and index, back to back, including the undefined pairs
  task t_sib;
    for (int ss = 0; ss < 4; ss++) for (int ix = 0; ix < 8; ix++) begin
      u_pf.issue(1'b1, 8'h01, 8'h04, {ss[1:0], ix[2:0], 3'h3}, 8'h00, 9'h100, 5'h00);
      check(scale_factor, 32'h1 << ss);
      check(base_code, 3'h3);
      check(index_reg, ix[2:0]);
      check(index_used, ix != 4);
      check(ea_undefined, ix == 4 && ss != 0);
    end
  endtask
  // Direction bit with and without the opcode owning it
  task t_dir;
    for (int k = 0; k < 4; k++) begin
      u_pf.issue(1'b1, {6'h00, k[0], 1'b0}, 8'hC0, 8'h00, 8'h00, {1'b1, k[1], 7'h00}, 5'h00);
      check(reg_is_dest, k[0] & k[1]);
    end
  endtask
  // Sign extension only for a set bit with a wider destination
  task t_imm;
    for (int k = 0; k < 12; k++) begin
      u_pf.issue(1'b1, {6'h20, k[0], 1'b0}, 8'hC0, 8'h00, {k[1], 7'h7F}, {4'hB, k[3:2], 3'h0}, 5'h00);
      check(imm_value, {{16{k[0] & k[1] & k[3]}}, {8{k[0] & k[1] & (k[3:2] != 0)}}, k[1], 7'h7F});
      check(imm_sign_extended, k[0] && k[3:2] != 0);
    end
  endtask
  // All sixteen condition codes under several flag sets
  task t_cond;
    for (int fi = 0; fi < 4; fi++) for (int t = 0; t < 16; t++) begin
      u_pf.issue(1'b1, {4'h7, t[3:0]}, 8'hC0, 8'h00, 8'h00, 9'h104, 5'(fi * 11));
      check(cond_code, t[3:1]);
      check(cond_negate, t[0]);
      check(cond_true, cond_of(t[3:1], 5'(fi * 11)) ^ t[0]);
    end
  endtask
  // Every selector code in every special-register class
  task t_sreg;
    logic ok;
    for (int cl = 1; cl < 4; cl++) for (int e = 0; e < 8; e++) begin
      u_pf.issue(1'b1, 8'h20, {2'h3, e[2:0], 3'h0}, 8'h00, 8'h00, {7'h40, cl[1:0]}, 5'h00);
      ok = (cl == 1) ? e inside {0, 2, 3} : (cl == 2) ? e inside {[0:3], 6, 7} : e >= 3;
      check(invalid_opcode, !ok);
      check(sreg_valid, ok);
      check(sreg_index, e[2:0]);
    end
  endtask
  // Lead pattern, memory formats, register forms and addressing bytes
  task t_fp;
    u_pf.issue(1'b1, 8'hD0, 8'hC0, 8'h00, 8'h00, 9'h100, 5'h00);
    check(is_fp, 1'b0);
    for (int mf = 0; mf < 4; mf++) begin
      u_pf.issue(1'b1, {5'h1B, mf[1:0], 1'b0}, 8'h00, 8'h00, 8'h00, 9'h100, 5'h00);
      check(is_fp, 1'b1);
      check(memory_format, mf[1:0]);
    end
    for (int k = 0; k < 64; k++) begin
      u_pf.issue(1'b1, {5'h1B, k[5], k[4], 1'b0}, {4'hC, k[3:0]}, 8'h00, 8'h00, 9'h100, 5'h00);
      check(fp_form, IFD_FF_REG);
      check(fp_pop, k[4]);
      check(fp_dest_is_elem, k[5]);
      check(fp_src_op_dest, k[3] ^ k[5]);
      check(stack_element, k[2:0]);
    end
    // Forms 4 and 5 keep the register-form fields clear
    for (int k = 0; k < 2; k++) begin
      u_pf.issue(1'b1, {6'h36, k[0], 1'b1}, 8'hE5, 8'h00, 8'h00, 9'h100, 5'h00);
      check({fp_form, fp_pop, stack_element}, {k[0] ? IFD_FF_F5 : IFD_FF_F4, 4'h0});
    end
    u_pf.issue(1'b1, 8'hD9, 8'h44, 8'h05, 8'h00, 9'h100, 5'h00);
    check({sib_present, disp_bytes}, 4'h9);
    u_pf.issue(1'b1, 8'hD9, 8'h86, 8'h00, 8'h00, 9'h000, 5'h00);
    check({sib_present, disp_bytes}, 4'h2);
    u_pf.issue(1'b1, 8'hD9, 8'h05, 8'h00, 8'h00, 9'h100, 5'h00);
    check({sib_present, disp_bytes}, 4'h4);
  endtask
  // Disabled edges freeze, idle cycles drop valid, reset in mid-run clears
  task t_hold;
    u_pf.issue(1'b1, 8'h20, 8'hC0, 8'h00, 8'h11, 9'h120, 5'h00);
    u_pf.issue(1'b0, 8'h20, 8'hC0, 8'h00, 8'h22, 9'h120, 5'h00);
    check(imm_value, 32'h00000011);
    u_pf.idle(1'b1);
    check({out_valid, imm_value}, 33'h000000011);
    @(negedge clock);
    reset = 1'b1;
    @(posedge clock);
    #1;
    check({out_valid, scale_factor, index_reg, imm_value}, 40'h0C00000000);
    @(negedge clock);
    reset = 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    check({out_valid, scale_factor, index_reg, imm_value}, 40'h0C00000000);
    t_sib();
    t_dir();
    t_imm();
    t_cond();
    t_sreg();
    t_fp();
    t_hold();
    report_and_stop();
  end
endmodule

bind ifd_decoder ifd_decoder_sva u_sva (.clock(clock), .reset(reset), .clock_enable(clock_enable),
  .in_valid(in_valid), .has_dir(has_dir), .has_sign(has_sign), .imm_is_8(imm_is_8), .op_byte0(op_byte0),
  .op_byte1(op_byte1), .sib_byte(sib_byte), .imm8(imm8), .sreg_class(sreg_class), .sib_present(sib_present),
  .index_used(index_used), .ea_undefined(ea_undefined), .reg_is_dest(reg_is_dest), .cond_negate(cond_negate),
  .invalid_opcode(invalid_opcode), .is_fp(is_fp), .fp_pop(fp_pop), .fp_dest_is_elem(fp_dest_is_elem),
  .fp_src_op_dest(fp_src_op_dest), .scale_factor(scale_factor), .index_reg(index_reg), .base_code(base_code),
  .cond_code(cond_code), .fp_form(fp_form), .stack_element(stack_element), .memory_format(memory_format),
  .imm_value(imm_value));
`default_nettype wire
